// file: include/fault_supervisor_consts.svh
// Timing counts, field values and reset values for the fault supervisor.
// Assumes the includer works at the 200 MHz system clock rate.
`ifndef FAULT_SUPERVISOR_CONSTS_SVH
`define FAULT_SUPERVISOR_CONSTS_SVH
// -----------------------------------------------------------------------------
// Clock and time figures
// -----------------------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define SHORT_FILTER_MS 4
`define SHORT_FILTER_CYC ((`SHORT_FILTER_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define OV_FILTER_US 10
`define OV_FILTER_CYC ((`OV_FILTER_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define COOL_DOWN_S 1
`define COOL_DOWN_CYC ((`COOL_DOWN_S * 64'd1000000000000) / `CLK_PERIOD_PS)
// -----------------------------------------------------------------------------
// Field values and reset values
// -----------------------------------------------------------------------------
`define THRESH_DEFAULT 2'h0
`define BUS_FAIL_NONE 2'h0
`define BUS_FAIL_THERMAL 2'h1
`define NUM_SWITCHES 4
`endif

// file: include/fault_supervisor_pkg.sv
// Types shared by the fault supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package fault_supervisor_pkg;
   // --------------------------------------------------------------------------
   // Operating modes
   // --------------------------------------------------------------------------
   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h1,
      MODE_FAILSAFE = 4'h2,
      MODE_RESTART = 4'h4,
      MODE_STOP = 4'h8
   } mode_e;
   // --------------------------------------------------------------------------
   // Comparator bundle
   // --------------------------------------------------------------------------
   typedef struct packed {
      logic battery_low;
      logic main_below_thresh;
      logic main_over;
      logic aux_current_limit;
      logic aux_low;
      logic secondary_low;
      logic transceiver_low;
      logic hot_secondary;
      logic hot_aux;
      logic hot_transceiver;
      logic hot_switches;
      logic main_prewarn;
      logic main_shutdown;
   } comparators_s;
   typedef struct packed {
      logic main_short_flag;
      logic aux_overcurrent_flag;
      logic aux_undervoltage_flag;
      logic secondary_undervoltage_flag;
      logic transceiver_supply_low_flag;
      logic first_level_thermal_flag;
      logic secondary_overtemp_flag;
      logic aux_overtemp_flag;
      logic thermal_prewarning_flag;
      logic second_level_thermal_flag;
      logic main_overvoltage_flag;
      logic failure_flag;
   } flags_s;
endpackage

// file: design/input_sync.sv
// Three-stage synchroniser; a change is taken when stages two and three agree.
// Assumes asynchronous comparator levels on the input bus.
`timescale 1ns/100ps
module input_sync #(
   parameter int WIDTH = 13
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
   wire [WIDTH-1:0] next_sync = (agree & stage3) | (~agree & sync_out);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         sync_out <= next_sync;
      end
   end
endmodule // input_sync

// file: design/supply_thermal_fault_supervisor.sv
// Fault supervisor: supply short, aux regulator, undervoltage and thermal faults.
// Assumes comparator levels arrive asynchronously; host clears are one-cycle pulses.
//
// Notes on behaviour
// - Main short supervision only while battery is above undervoltage.
// - Main not up within filter after power-up or wake: short reaction.
// - Main below threshold longer than filter: same short reaction.
// - Bus wake or wake input leaves fail-safe after a short reaction.
// - Load sharing: PNP off on low battery or stop, per keep bits.
// - Stand-alone: PNP off on low battery unless kept; flag overcurrent, undervoltage.
// - No short flag during main power-up; no aux low flag at aux turn-on.
// - Secondary or transceiver supply low sets sticky flag, host clears.
// - No secondary low flag while secondary switches on or off.
// - First-level heat switches off that block, sets flag clearable after cooling.
// - First-level check per block only while that block is on.
// - Secondary overheat: off, enable cleared, status set, host re-enables.
// - Stand-alone aux overheat: off, enable cleared, status set, host re-enables.
// - Load-sharing aux overheat: status set, off, back on when cool.
// - Transceiver overheat: transmitter off, receive only, bus fail 01, auto resume.
// - Any switch overheat: all switches off, controls cleared, fault bits set.
// - Thermal flags stay set until host clears them.
// - Main prewarning flag while main on, clearable after condition ends.
// - Second-level heat: fail-safe for cool-down, then restart, then normal.
// - Second-level flag set while main on, cleared in normal mode after cooling.
// - Main overvoltage must persist for the filter time before acting.
// - Four reset thresholds, first one after reset.
// - Cool-down in fail-safe lasts about one second.
`timescale 1ns/100ps
`include "fault_supervisor_consts.svh"
module supply_thermal_fault_supervisor #(
   parameter int NSW = `NUM_SWITCHES,
   parameter longint SHORT_FILTER = `SHORT_FILTER_CYC,
   parameter longint COOL_DOWN = `COOL_DOWN_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Comparators
   input wire fault_supervisor_pkg::comparators_s comp,
   // Events
   input wire logic power_up_start,
   input wire logic bus_wake,
   input wire logic wake_inputs,
   input wire logic stop_request,
   input wire logic normal_request,
   // Host configuration
   input wire logic load_sharing,
   input wire logic aux_keep_on_low_battery,
   input wire logic shared_keep_on_in_stop,
   input wire logic [1:0] thresh_write,
   input wire logic thresh_load,
   input wire logic secondary_on_set,
   input wire logic aux_on_set,
   input wire logic [NSW-1:0] switch_write,
   input wire logic switch_load,
   input wire fault_supervisor_pkg::flags_s clear_flags,
   input wire logic [NSW-1:0] clear_switch_faults,
   // Outputs to power stages
   output logic main_supply_on,
   output logic fail_outputs,
   output logic secondary_supply_enable,
   output logic aux_regulator_enable,
   output logic aux_drive,
   output logic transmitter_enable,
   output logic [NSW-1:0] high_side_switches,
   output logic [1:0] reset_thresh_sel,
   output logic [1:0] bus_failure,
   output logic main_overvoltage_event,
   // Status
   output fault_supervisor_pkg::mode_e mode,
   output fault_supervisor_pkg::flags_s flags,
   output logic [NSW-1:0] switch_fault_flags
);
   // -------------------------------------------------------------------------
   // Input synchronisation
   // -------------------------------------------------------------------------
   fault_supervisor_pkg::comparators_s cs;
   input_sync #(.WIDTH($bits(fault_supervisor_pkg::comparators_s))) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(comp),
      .sync_out(cs)
   );
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [31:0] short_cnt;
   logic [31:0] cool_cnt;
   logic [15:0] ov_cnt;
   logic short_latched;
   logic aux_turning_on;
   logic secondary_prev;
   fault_supervisor_pkg::mode_e next_mode;
   // -------------------------------------------------------------------------
   // Decoding
   // -------------------------------------------------------------------------
   wire short_watch = main_supply_on && !cs.battery_low;
   wire short_expired = short_watch && cs.main_below_thresh
      && (short_cnt >= SHORT_FILTER[31:0] - 32'h1);
   wire short_hit = short_expired && !short_latched;
   wire second_level_thermal_flag_hit = main_supply_on && cs.main_shutdown;
   wire cool_done = (mode == fault_supervisor_pkg::MODE_FAILSAFE) && !short_latched
      && (cool_cnt >= COOL_DOWN[31:0] - 32'h1);
   wire wake_any = bus_wake || wake_inputs;
   wire sec_hot = secondary_supply_enable && cs.hot_secondary;
   wire aux_hot = aux_regulator_enable && cs.hot_aux;
   wire trx_hot = transmitter_enable && cs.hot_transceiver;
   wire sw_hot = (|high_side_switches) && cs.hot_switches;
   wire any_first_level_thermal_flag = sec_hot || aux_hot || trx_hot || sw_hot;
   wire any_hot = cs.hot_secondary || cs.hot_aux || cs.hot_transceiver || cs.hot_switches;
   wire sec_switching = secondary_prev != secondary_supply_enable;
   wire aux_cut_battery = cs.battery_low && !aux_keep_on_low_battery;
   wire aux_cut_stop = load_sharing && (mode == fault_supervisor_pkg::MODE_STOP)
      && !shared_keep_on_in_stop;
   wire aux_cut_heat = load_sharing && cs.hot_aux;
   wire next_aux_drive = aux_regulator_enable && !aux_cut_battery && !aux_cut_stop
      && !aux_cut_heat;
   wire ov_full = ov_cnt >= 16'(`OV_FILTER_CYC) - 16'h1;
   // Set wins over clear on every flag
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction
   // -------------------------------------------------------------------------
   // Mode machine
   // -------------------------------------------------------------------------
   always_comb begin
      next_mode = mode;
      case (mode)
         fault_supervisor_pkg::MODE_NORMAL: begin
            if (short_hit || second_level_thermal_flag_hit) next_mode = fault_supervisor_pkg::MODE_FAILSAFE;
            else if (stop_request) next_mode = fault_supervisor_pkg::MODE_STOP;
         end
         fault_supervisor_pkg::MODE_STOP: begin
            if (short_hit || second_level_thermal_flag_hit) next_mode = fault_supervisor_pkg::MODE_FAILSAFE;
            else if (normal_request) next_mode = fault_supervisor_pkg::MODE_NORMAL;
         end
         fault_supervisor_pkg::MODE_FAILSAFE: begin
            if (short_latched && wake_any) next_mode = fault_supervisor_pkg::MODE_RESTART;
            else if (cool_done) next_mode = fault_supervisor_pkg::MODE_RESTART;
         end
         fault_supervisor_pkg::MODE_RESTART: begin
            if (second_level_thermal_flag_hit) next_mode = fault_supervisor_pkg::MODE_FAILSAFE;
            else next_mode = fault_supervisor_pkg::MODE_NORMAL;
         end
         default: next_mode = fault_supervisor_pkg::MODE_RESTART;
      endcase
   end
   // -------------------------------------------------------------------------
   // Timers and supply control
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode <= fault_supervisor_pkg::MODE_RESTART;
         short_cnt <= 32'h0;
         cool_cnt <= 32'h0;
         ov_cnt <= 16'h0;
         short_latched <= 1'b0;
         main_supply_on <= 1'b1;
         fail_outputs <= 1'b0;
         main_overvoltage_event <= 1'b0;
      end else begin
         mode <= next_mode;
         // Filter window restarts at every power-up start, and while the main supply is off
         short_cnt <= (short_watch && cs.main_below_thresh && !short_expired && !power_up_start)
            ? short_cnt + 32'h1 : 32'h0;
         cool_cnt <= (mode == fault_supervisor_pkg::MODE_FAILSAFE) ? cool_cnt + 32'h1 : 32'h0;
         ov_cnt <= (cs.main_over && !ov_full) ? ov_cnt + 16'h1 : (cs.main_over ? ov_cnt : 16'h0);
         main_overvoltage_event <= cs.main_over && ov_full;
         if (short_hit) begin
            short_latched <= 1'b1;
            main_supply_on <= 1'b0;
            fail_outputs <= 1'b1;
         end else if (short_latched && wake_any
               && mode == fault_supervisor_pkg::MODE_FAILSAFE) begin
            short_latched <= 1'b0;
            main_supply_on <= 1'b1;
            fail_outputs <= 1'b0;
         end else if (second_level_thermal_flag_hit) begin
            fail_outputs <= 1'b1;
         end else if (next_mode == fault_supervisor_pkg::MODE_NORMAL) begin
            fail_outputs <= 1'b0;
         end
      end
   end
   // -------------------------------------------------------------------------
   // Block enables and thermal shutdown
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         secondary_supply_enable <= 1'b0;
         secondary_prev <= 1'b0;
         aux_regulator_enable <= 1'b0;
         aux_turning_on <= 1'b0;
         aux_drive <= 1'b0;
         transmitter_enable <= 1'b1;
         high_side_switches <= '0;
         reset_thresh_sel <= `THRESH_DEFAULT;
         bus_failure <= `BUS_FAIL_NONE;
      end else begin
         secondary_prev <= secondary_supply_enable;
         if (sec_hot) secondary_supply_enable <= 1'b0;
         else if (secondary_on_set) secondary_supply_enable <= 1'b1;
         if (aux_hot && !load_sharing) aux_regulator_enable <= 1'b0;
         else if (aux_on_set) aux_regulator_enable <= 1'b1;
         aux_drive <= next_aux_drive;
         aux_turning_on <= next_aux_drive && !aux_drive;
         transmitter_enable <= !cs.hot_transceiver;
         if (cs.hot_transceiver) bus_failure <= `BUS_FAIL_THERMAL;
         if (sw_hot) high_side_switches <= '0;
         else if (switch_load) high_side_switches <= switch_write;
         if (thresh_load) reset_thresh_sel <= thresh_write;
      end
   end
   // -------------------------------------------------------------------------
   // Sticky status flags
   // -------------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags <= '0;
         switch_fault_flags <= '0;
      end else begin
         // Ramp-up dips never flag: set only at filter expiry
         flags.main_short_flag <= sticky(flags.main_short_flag, short_hit,
            clear_flags.main_short_flag);
         flags.failure_flag <= sticky(flags.failure_flag, short_hit, clear_flags.failure_flag);
         flags.aux_overcurrent_flag <= sticky(flags.aux_overcurrent_flag,
            !load_sharing && aux_drive && cs.aux_current_limit,
            clear_flags.aux_overcurrent_flag);
         flags.aux_undervoltage_flag <= sticky(flags.aux_undervoltage_flag,
            !load_sharing && aux_drive && !aux_turning_on && cs.aux_low,
            clear_flags.aux_undervoltage_flag);
         flags.secondary_undervoltage_flag <= sticky(flags.secondary_undervoltage_flag,
            secondary_supply_enable && !sec_switching && cs.secondary_low,
            clear_flags.secondary_undervoltage_flag);
         flags.transceiver_supply_low_flag <= sticky(flags.transceiver_supply_low_flag,
            cs.transceiver_low, clear_flags.transceiver_supply_low_flag);
         flags.first_level_thermal_flag <= sticky(flags.first_level_thermal_flag, any_first_level_thermal_flag,
            clear_flags.first_level_thermal_flag && !any_hot);
         flags.secondary_overtemp_flag <= sticky(flags.secondary_overtemp_flag, sec_hot,
            clear_flags.secondary_overtemp_flag && !cs.hot_secondary);
         flags.aux_overtemp_flag <= sticky(flags.aux_overtemp_flag, aux_hot,
            clear_flags.aux_overtemp_flag && !cs.hot_aux);
         flags.thermal_prewarning_flag <= sticky(flags.thermal_prewarning_flag,
            main_supply_on && cs.main_prewarn,
            clear_flags.thermal_prewarning_flag && !cs.main_prewarn);
         flags.second_level_thermal_flag <= sticky(flags.second_level_thermal_flag, second_level_thermal_flag_hit,
            clear_flags.second_level_thermal_flag && !cs.main_shutdown
            && mode == fault_supervisor_pkg::MODE_NORMAL);
         flags.main_overvoltage_flag <= sticky(flags.main_overvoltage_flag,
            cs.main_over && ov_full, clear_flags.main_overvoltage_flag);
         switch_fault_flags <= sw_hot ? high_side_switches | switch_fault_flags
            : switch_fault_flags & ~(clear_switch_faults & {NSW{!cs.hot_switches}});
      end
   end
   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   short_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      short_hit |=> !main_supply_on && fail_outputs && flags.failure_flag)
      else $error("short reaction incomplete");
   short_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
      short_hit |=> mode == fault_supervisor_pkg::MODE_FAILSAFE)
      else $error("short did not enter fail-safe");
   wake_leave_a: assert property (@(posedge sys_clk) disable iff (rst)
      (short_latched && wake_any && mode == fault_supervisor_pkg::MODE_FAILSAFE)
      |=> mode == fault_supervisor_pkg::MODE_RESTART ##1 mode != fault_supervisor_pkg::MODE_RESTART)
      else $error("wake did not leave fail-safe");
   sec_heat_a: assert property (@(posedge sys_clk) disable iff (rst)
      sec_hot |=> !secondary_supply_enable && flags.secondary_overtemp_flag)
      else $error("secondary not cut on heat");
   switch_heat_a: assert property (@(posedge sys_clk) disable iff (rst)
      sw_hot |=> high_side_switches == '0 && $past(high_side_switches) == (switch_fault_flags
      & $past(high_side_switches)))
      else $error("switches not cut on heat");
   trx_heat_a: assert property (@(posedge sys_clk) disable iff (rst)
      cs.hot_transceiver |=> !transmitter_enable && bus_failure == `BUS_FAIL_THERMAL)
      else $error("transmitter not cut on heat");
   second_level_thermal_flag_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      (flags.second_level_thermal_flag && mode != fault_supervisor_pkg::MODE_NORMAL)
      |=> flags.second_level_thermal_flag)
      else $error("second-level flag cleared outside normal");
   ov_filter_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(main_overvoltage_event) |-> $past(cs.main_over, 2))
      else $error("overvoltage acted without persistence");
   aux_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
      aux_cut_stop |=> !aux_drive)
      else $error("aux kept on in stop");
   restart_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
      (cool_done && !wake_any) |=> mode == fault_supervisor_pkg::MODE_RESTART)
      else $error("cool-down did not restart");
endmodule // supply_thermal_fault_supervisor

// file: verif/comparator_model.sv
// Behavioural model of the analog comparators beside the fault supervisor.
// Assumes the bench requests fault levels; supply state comes from the design.
`timescale 1ns/100ps
module comparator_model (
   // Requests from the bench
   input wire fault_supervisor_pkg::comparators_s fault_req,
   // Supply state
   input wire logic main_supply_on,
   // Comparator levels
   output fault_supervisor_pkg::comparators_s comp
);
   // -----------------------------------------------------------------
   // A switched-off main supply reads below threshold
   // -----------------------------------------------------------------
   always_comb begin
      comp = fault_req;
      comp.main_below_thresh = fault_req.main_below_thresh | ~main_supply_on;
   end
endmodule // comparator_model

// file: verif/supply_thermal_fault_supervisor_tb.sv
// Self-checking bench for the fault supervisor.
// Assumes short filter and cool-down counts shortened by parameter.
`timescale 1ns/100ps
module supply_thermal_fault_supervisor_tb;
   localparam int SF = 50;
   localparam int CD = 100;
   typedef struct packed {
      logic [12:0] cond;
      logic [11:0] flag;
      logic [11:0] outs;
   } row_s;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   fault_supervisor_pkg::comparators_s fault_req = '0;
   fault_supervisor_pkg::comparators_s comp;
   fault_supervisor_pkg::flags_s clear_flags = '0;
   fault_supervisor_pkg::flags_s flags;
   fault_supervisor_pkg::mode_e mode;
   logic wake_inputs = 0, load_sharing = 0, keep_low = 0, thresh_load = 0;
   logic [1:0] thresh_write = 2'h0;
   logic sec_set = 0, aux_set = 0, switch_load = 0;
   logic pwr_start = 0, bus_wk = 0, stop_req = 0, normal_req = 0, keep_stop = 0;
   logic [3:0] switch_write = 4'h0, clear_sw = 4'h0, hs, sff;
   logic main_on, fail_out, sec_en, aux_en, aux_drive, tx_en, ov_ev;
   logic [1:0] thresh_sel, bus_fail;
   int mismatches = 0, checks_done = 0, cnt;
   row_s rows [8];
   wire logic [11:0] outs = {tx_en, sec_en, bus_fail, hs, sff};

   always #2.5 sys_clk = ~sys_clk;

   comparator_model model (.fault_req(fault_req), .main_supply_on(main_on), .comp(comp));

   supply_thermal_fault_supervisor #(.SHORT_FILTER(SF), .COOL_DOWN(CD)) DUT (
      .sys_clk(sys_clk), .rst(rst), .comp(comp), .power_up_start(pwr_start),
      .bus_wake(bus_wk), .wake_inputs(wake_inputs), .stop_request(stop_req),
      .normal_request(normal_req), .load_sharing(load_sharing),
      .aux_keep_on_low_battery(keep_low), .shared_keep_on_in_stop(keep_stop),
      .thresh_write(thresh_write), .thresh_load(thresh_load),
      .secondary_on_set(sec_set), .aux_on_set(aux_set), .switch_write(switch_write),
      .switch_load(switch_load), .clear_flags(clear_flags),
      .clear_switch_faults(clear_sw), .main_supply_on(main_on), .fail_outputs(fail_out),
      .secondary_supply_enable(sec_en), .aux_regulator_enable(aux_en),
      .aux_drive(aux_drive), .transmitter_enable(tx_en), .high_side_switches(hs),
      .reset_thresh_sel(thresh_sel), .bus_failure(bus_fail),
      .main_overvoltage_event(ov_ev), .mode(mode), .flags(flags),
      .switch_fault_flags(sff));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic pulse_clear;
      clear_flags = '1;
      clear_sw = 4'hf;
      tick(1);
      clear_flags = '0;
      clear_sw = 4'h0;
   endtask

   task automatic conclude;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #250000;
      mismatches++;
      conclude();
   end

   initial begin
      // Rows: condition, flags expected, {tx, sec, bus fail, switches, switch faults}
      rows[0] = '{13'h0080, 12'h100, 12'hcf0};
      rows[1] = '{13'h0040, 12'h080, 12'hcf0};
      rows[2] = '{13'h0002, 12'h008, 12'hcf0};
      rows[3] = '{13'h0200, 12'h400, 12'hcf0};
      rows[4] = '{13'h0008, 12'h040, 12'h5f0};
      rows[5] = '{13'h0020, 12'h060, 12'h9f0};
      rows[6] = '{13'h0004, 12'h040, 12'h90f};
      rows[7] = '{13'h0010, 12'h050, 12'h900};
      tick(10);
      check({12'h0, mode}, 16'h4);
      check({14'h0, thresh_sel}, 16'h0);
      rst = 1'b0;
      tick(2);
      check({12'h0, mode}, 16'h1);
      sec_set = 1;
      aux_set = 1;
      switch_write = 4'hf;
      switch_load = 1;
      tick(1);
      {sec_set, aux_set, switch_load} = 3'h0;
      tick(30);
      for (int i = 0; i < 8; i++) begin
         fault_req = rows[i].cond;
         tick(8);
         check({4'h0, flags}, {4'h0, rows[i].flag});
         check({4'h0, outs}, {4'h0, rows[i].outs});
         pulse_clear();
         check({4'h0, flags}, {4'h0, rows[i].flag});
         check({4'h0, outs}, {4'h0, rows[i].outs});
         fault_req = '0;
         tick(8);
         check({4'h0, flags}, {4'h0, rows[i].flag});
         pulse_clear();
         tick(2);
         check({4'h0, flags}, 16'h0);
      end
      check({15'h0, aux_en}, 16'h0);
      thresh_write = 2'h3;
      {thresh_load, aux_set} = 2'h3;
      tick(1);
      {thresh_load, aux_set} = 2'h0;
      tick(2);
      check({14'h0, thresh_sel}, 16'h3);
      load_sharing = 1;
      fault_req = 13'h1800;
      tick(SF + 20);
      check({15'h0, main_on}, 16'h1);
      check({15'h0, aux_drive}, 16'h0);
      keep_low = 1;
      tick(8);
      check({15'h0, aux_drive}, 16'h1);
      fault_req = 13'h0010;
      tick(8);
      check({14'h0, aux_en, aux_drive}, 16'h2);
      fault_req = '0;
      tick(8);
      check({14'h0, aux_en, aux_drive}, 16'h3);
      pulse_clear();
      stop_req = 1;
      tick(1);
      stop_req = 0;
      tick(2);
      check({11'h0, aux_drive, mode}, 16'h8);
      keep_stop = 1;
      tick(2);
      check({15'h0, aux_drive}, 16'h1);
      normal_req = 1;
      tick(1);
      {normal_req, keep_stop} = 2'h0;
      check({12'h0, mode}, 16'h1);
      fault_req = '0;
      {load_sharing, keep_low} = 2'h0;
      tick(10);
      fault_req = 13'h0800;
      tick(SF - 10);
      check({15'h0, main_on}, 16'h1);
      tick(30);
      check({13'h0, main_on, fail_out, mode == fault_supervisor_pkg::MODE_FAILSAFE}, 16'h3);
      check({4'h0, flags}, 16'h801);
      fault_req = '0;
      wake_inputs = 1;
      tick(1);
      wake_inputs = 0;
      tick(20);
      check({11'h0, main_on, mode}, 16'h11);
      pulse_clear();
      tick(10);
      fault_req = 13'h0001;
      tick(8);
      fault_req = '0;
      check({12'h0, mode}, 16'h2);
      check({14'h0, fail_out, flags.second_level_thermal_flag}, 16'h3);
      tick(8);
      pulse_clear();
      check({15'h0, flags.second_level_thermal_flag}, 16'h1);
      cnt = 17;
      while (mode !== fault_supervisor_pkg::MODE_NORMAL && cnt < 1000) begin
         tick(1);
         cnt++;
      end
      check({15'h0, cnt >= CD && cnt <= CD + 30}, 16'h1);
      pulse_clear();
      tick(2);
      check({4'h0, flags}, 16'h0);
      // Main never rises after a power-up start
      fault_req = 13'h0800;
      pwr_start = 1;
      tick(1);
      pwr_start = 0;
      tick(SF + 20);
      check({4'h0, flags}, 16'h801);
      fault_req = '0;
      bus_wk = 1;
      tick(1);
      bus_wk = 0;
      tick(20);
      check({11'h0, main_on, mode}, 16'h11);
      pulse_clear();
      // Overvoltage filter of 2000 cycles plus sync delay
      fault_req = 13'h0400;
      tick(1990);
      check({15'h0, ov_ev}, 16'h0);
      tick(30);
      check({3'h0, flags, ov_ev}, 16'h5);
      conclude();
   end
endmodule // supply_thermal_fault_supervisor_tb
